// >>> hdl/xldd_pkg.sv
package xldd_pkg;

  localparam int          XLDD_DATA_W      = 32;
  localparam int          XLDD_DIV_STEPS   = 32;
  // Opcode patterns
  localparam logic [9:0]  OP_DIVL_HI       = 10'h131;
  localparam logic [3:0]  OP_REGXOR_HI     = 4'hB;
  localparam logic [7:0]  OP_IMMXOR_HI     = 8'h0A;
  localparam logic [15:0] OP_CCRXOR        = 16'h0A3C;
  // Divide extension word fields
  localparam int          EXT_FIXED_BIT    = 15;
  localparam int          EXT_DQ_LSB       = 12;
  localparam int          EXT_SIGNED_BIT   = 11;
  localparam int          EXT_SIZE_BIT     = 10;
  localparam int          EXT_DR_LSB       = 0;
  // Register xor: opmode bit 8 set means data register to effective address
  localparam int          RX_DIR_BIT       = 8;
  // Effective address modes and registers
  localparam logic [2:0]  EA_MODE_DREG     = 3'h0;
  localparam logic [2:0]  EA_MODE_AREG     = 3'h1;
  localparam logic [2:0]  EA_MODE_EXT      = 3'h7;
  localparam logic [2:0]  EA_REG_ABS_L     = 3'h1;
  localparam logic [2:0]  EA_REG_IMM       = 3'h4;
  // Condition code bit positions
  localparam int          CCR_X            = 4;
  localparam int          CCR_N            = 3;
  localparam int          CCR_Z            = 2;
  localparam int          CCR_V            = 1;
  localparam int          CCR_C            = 0;
  localparam logic [4:0]  CCR_RESET        = 5'h00;
  localparam logic [31:0] DREG_RESET       = 32'h00000000;

  typedef enum logic [1:0] {
    SZ_BYTE = 2'b00,
    SZ_WORD = 2'b01,
    SZ_LONG = 2'b10,
    SZ_NONE = 2'b11
  } xldd_size_t;

  typedef enum logic [1:0] {
    K_DIV    = 2'b00,
    K_REGXOR = 2'b01,
    K_IMMXOR = 2'b10,
    K_CCRXOR = 2'b11
  } xldd_kind_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [2:0]  mode;
    logic [2:0]  reg_n;
    xldd_size_t  size;
    logic [31:0] wdata;
  } xldd_ea_req_t;

endpackage : xldd_pkg

// >>> hdl/xldd_udiv.sv
`timescale 1ns/1ps
module xldd_udiv
  import xldd_pkg::*;
#(
  parameter int W = XLDD_DIV_STEPS
) (
  input  wire logic           i_clk,
  input  wire logic           i_sys_rst,
  input  wire logic           i_start,
  input  wire logic [2*W-1:0] i_dividend,
  input  wire logic [W-1:0]   i_divisor,
  output logic                o_busy,
  output logic                o_done,
  output logic [W-1:0]        o_quot,
  output logic [W-1:0]        o_rem,
  output logic                o_ovf
);

  if (W < 2) begin : g_bad_w
    $error("xldd_udiv: W must be at least 2");
  end

  localparam int CW = $clog2(W + 1);

  logic [W-1:0]  rem_ff;
  logic [W-1:0]  quo_ff;
  logic [W-1:0]  div_ff;
  logic [CW-1:0] cnt_ff;
  logic          busy_ff;
  logic          done_ff;
  logic          ovf_ff;

  // High half at or above the divisor means the quotient cannot fit
  wire           w_ovf   = i_dividend[2*W-1:W] >= i_divisor;
  wire [W:0]     w_shift = {rem_ff, quo_ff[W-1]};
  wire [W:0]     w_diff  = w_shift - {1'b0, div_ff};
  wire           w_bit   = ~w_diff[W];

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rem_ff  <= '0;
      quo_ff  <= '0;
      div_ff  <= '0;
      cnt_ff  <= '0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      ovf_ff  <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (i_start && !busy_ff) begin
        ovf_ff  <= w_ovf;
        done_ff <= w_ovf;
        busy_ff <= ~w_ovf;
        rem_ff  <= i_dividend[2*W-1:W];
        quo_ff  <= i_dividend[W-1:0];
        div_ff  <= i_divisor;
        cnt_ff  <= CW'(W);
      end else if (busy_ff) begin
        rem_ff <= w_bit ? w_diff[W-1:0] : w_shift[W-1:0];
        quo_ff <= {quo_ff[W-2:0], w_bit};
        cnt_ff <= cnt_ff - 1'b1;
        if (cnt_ff == CW'(1)) begin
          busy_ff <= 1'b0;
          done_ff <= 1'b1;
        end
      end
    end
  end

  assign o_busy = busy_ff;
  assign o_done = done_ff;
  assign o_quot = quo_ff;
  assign o_rem  = rem_ff;
  assign o_ovf  = ovf_ff;

  chk_ovf_early_done: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    (i_start && !busy_ff && w_ovf) |=> (o_done && o_ovf))
    else $error("overflow did not finish in one cycle");

  chk_div_latency: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    (i_start && !busy_ff && !w_ovf) |-> ##33 (o_done && !o_ovf))
    else $error("divide did not finish after 33 cycles");

endmodule : xldd_udiv

// >>> hdl/xldd_decode.sv
`timescale 1ns/1ps
module xldd_decode
  import xldd_pkg::*;
#(
  parameter int NUM_DREGS = 8
) (
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_fetch_valid,
  input  wire logic [15:0] i_fetch_word,
  output logic             o_fetch_ready,
  output xldd_ea_req_t     o_ea_req,
  input  wire logic        i_ea_ack,
  input  wire logic [31:0] i_ea_rdata,
  input  wire logic        i_dreg_load,
  input  wire logic [2:0]  i_dreg_load_idx,
  input  wire logic [31:0] i_dreg_load_data,
  input  wire logic        i_ccr_load,
  input  wire logic [4:0]  i_ccr_load_data,
  input  wire logic [2:0]  i_dreg_rd_idx,
  output logic [31:0]      o_dreg_rd_data,
  output logic [7:0]       o_ccr,
  output logic             o_done,
  output logic             o_illegal,
  output logic             o_div_zero_trap
);

  if (NUM_DREGS != 8) begin : g_bad_regs
    $error("xldd_decode: register fields are 3 bits, need 8");
  end

  typedef enum logic [3:0] {
    S_OP     = 4'h0,
    S_EXT    = 4'h1,
    S_IMM    = 4'h2,
    S_EA_RD  = 4'h3,
    S_DIVCHK = 4'h4,
    S_DIV    = 4'h5,
    S_EXEC   = 4'h6,
    S_EA_WR  = 4'h7
  } xldd_state_t;

  function automatic logic [31:0] size_mask(input xldd_size_t s);
    case (s)
      SZ_BYTE: size_mask = 32'h000000FF;
      SZ_WORD: size_mask = 32'h0000FFFF;
      default: size_mask = 32'hFFFFFFFF;
    endcase
  endfunction : size_mask

  function automatic logic size_msb(input xldd_size_t s,
                                    input logic [31:0] v);
    case (s)
      SZ_BYTE: size_msb = v[7];
      SZ_WORD: size_msb = v[15];
      default: size_msb = v[31];
    endcase
  endfunction : size_msb

  // Alterable modes stop at absolute long; plain data modes reach immediate
  function automatic logic ea_ok(input logic [2:0] m,
                                 input logic [2:0] r,
                                 input logic       alt);
    ea_ok = (m != EA_MODE_AREG) &&
            !(m == EA_MODE_EXT && r > (alt ? EA_REG_ABS_L : EA_REG_IMM));
  endfunction : ea_ok

  xldd_state_t state_ff, nxt_state;
  xldd_kind_t  kind_ff;
  xldd_size_t  size_ff;
  logic [2:0]  mode_ff;
  logic [2:0]  ea_reg_ff;
  logic [2:0]  src_ff;
  logic [2:0]  dq_ff;
  logic [2:0]  dr_ff;
  logic        long_ff;
  logic [31:0] imm_ff;
  logic [1:0]  imm_left_ff;
  logic [31:0] opnd_ff;
  logic [31:0] res_ff;
  logic [4:0]  ccr_ff;
  logic [31:0] dreg_ff [NUM_DREGS];
  logic [31:0] rd_ff;
  logic        done_ff;
  logic        ill_ff;
  logic        trap_ff;

  wire         w_fire  = o_fetch_ready & i_fetch_valid;
  wire [15:0]  w_op    = i_fetch_word;
  wire [2:0]   w_mode  = w_op[5:3];
  wire [2:0]   w_reg   = w_op[2:0];
  wire         w_szok  = w_op[7:6] != SZ_NONE;
  wire         w_d_div = w_op[15:6] == OP_DIVL_HI &&
                         ea_ok(w_mode, w_reg, 1'b0);
  wire         w_d_rx  = w_op[15:12] == OP_REGXOR_HI &&
                         w_op[RX_DIR_BIT] && w_szok &&
                         ea_ok(w_mode, w_reg, 1'b1);
  wire         w_d_cc  = w_op == OP_CCRXOR;
  wire         w_d_ix  = !w_d_cc && w_op[15:8] == OP_IMMXOR_HI &&
                         w_szok && ea_ok(w_mode, w_reg, 1'b1);
  wire         w_d_ok  = w_d_div | w_d_rx | w_d_cc | w_d_ix;
  wire         w_ext_bad = w_op[EXT_SIGNED_BIT] |
                           w_op[EXT_FIXED_BIT];
  wire         w_src_imm = mode_ff == EA_MODE_EXT &&
                           ea_reg_ff == EA_REG_IMM;
  wire         w_dst_dn  = mode_ff == EA_MODE_DREG;
  wire         w_is_div  = kind_ff == K_DIV;
  wire         w_is_xor  = kind_ff == K_REGXOR || kind_ff == K_IMMXOR;

  // Divide operands
  wire [31:0]  w_divisor = w_dst_dn  ? dreg_ff[ea_reg_ff] :
                           w_src_imm ? imm_ff : opnd_ff;
  wire [31:0]  w_div_hi  = long_ff ? dreg_ff[dr_ff] : 32'h0;
  wire [63:0]  w_dividend = {w_div_hi, dreg_ff[dq_ff]};
  wire         w_div_zero = w_divisor == 32'h0;
  wire         w_dv_start = state_ff == S_DIVCHK && !w_div_zero;
  wire         w_dv_done;
  wire [31:0]  w_quot;
  wire [31:0]  w_rem;
  wire         w_ovf;

  // Xor datapath
  wire [31:0]  w_mask = size_mask(size_ff);
  wire [31:0]  w_xsrc = kind_ff == K_REGXOR ? dreg_ff[src_ff] : imm_ff;
  wire [31:0]  w_xdst = w_dst_dn ? dreg_ff[ea_reg_ff] : opnd_ff;
  wire [31:0]  w_xres = (w_xsrc ^ w_xdst) & w_mask;
  wire [31:0]  w_merged = (w_xdst & ~w_mask) | w_xres;
  wire         w_xneg = size_msb(size_ff, w_xres);

  xldd_udiv #(
    .W          (XLDD_DIV_STEPS)
  ) u_udiv (
    .i_clk      (i_clk),
    .i_sys_rst  (i_sys_rst),
    .i_start    (w_dv_start),
    .i_dividend (w_dividend),
    .i_divisor  (w_divisor),
    .o_busy     (),
    .o_done     (w_dv_done),
    .o_quot     (w_quot),
    .o_rem      (w_rem),
    .o_ovf      (w_ovf)
  );

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      S_OP: begin
        if (w_fire && w_d_ok) begin
          if (w_d_div)
            nxt_state = S_EXT;
          else if (w_d_rx)
            nxt_state = (w_mode == EA_MODE_DREG) ? S_EXEC : S_EA_RD;
          else
            nxt_state = S_IMM;
        end
      end
      S_EXT: begin
        if (w_fire) begin
          if (w_ext_bad)
            nxt_state = S_OP;
          else if (w_dst_dn)
            nxt_state = S_DIVCHK;
          else if (w_src_imm)
            nxt_state = S_IMM;
          else
            nxt_state = S_EA_RD;
        end
      end
      S_IMM: begin
        if (w_fire && imm_left_ff == 2'h1) begin
          if (w_is_div)
            nxt_state = S_DIVCHK;
          else if (kind_ff == K_CCRXOR || w_dst_dn)
            nxt_state = S_EXEC;
          else
            nxt_state = S_EA_RD;
        end
      end
      S_EA_RD: begin
        if (i_ea_ack)
          nxt_state = w_is_div ? S_DIVCHK : S_EXEC;
      end
      S_DIVCHK: nxt_state = w_div_zero ? S_OP : S_DIV;
      S_DIV: begin
        if (w_dv_done)
          nxt_state = S_EXEC;
      end
      S_EXEC:  nxt_state = (w_is_xor && !w_dst_dn) ? S_EA_WR : S_OP;
      S_EA_WR: nxt_state = i_ea_ack ? S_OP : S_EA_WR;
      default: nxt_state = S_OP;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst)
      state_ff <= S_OP;
    else
      state_ff <= nxt_state;
  end

  // Capture of decoded fields, immediates and memory operands
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      kind_ff     <= K_DIV;
      size_ff     <= SZ_LONG;
      mode_ff     <= EA_MODE_DREG;
      ea_reg_ff   <= 3'h0;
      src_ff      <= 3'h0;
      dq_ff       <= 3'h0;
      dr_ff       <= 3'h0;
      long_ff     <= 1'b0;
      imm_ff      <= 32'h0;
      imm_left_ff <= 2'h0;
      opnd_ff     <= 32'h0;
    end else begin
      if (state_ff == S_OP && w_fire) begin
        mode_ff     <= w_mode;
        ea_reg_ff   <= w_reg;
        src_ff      <= w_op[11:9];
        size_ff     <= xldd_size_t'(w_op[7:6]);
        imm_left_ff <= (w_op[7:6] == SZ_LONG) ? 2'h2 : 2'h1;
        kind_ff     <= w_d_div ? K_DIV :
                       w_d_rx  ? K_REGXOR :
                       w_d_cc  ? K_CCRXOR : K_IMMXOR;
        if (w_d_div || w_d_cc)
          size_ff <= w_d_div ? SZ_LONG : SZ_BYTE;
        if (w_d_div || w_d_cc)
          imm_left_ff <= w_d_div ? 2'h2 : 2'h1;
      end
      if (state_ff == S_EXT && w_fire) begin
        dq_ff   <= w_op[EXT_DQ_LSB +: 3];
        dr_ff   <= w_op[EXT_DR_LSB +: 3];
        long_ff <= w_op[EXT_SIZE_BIT];
      end
      if (state_ff == S_IMM && w_fire) begin
        imm_ff      <= {imm_ff[15:0], w_op};
        imm_left_ff <= imm_left_ff - 2'h1;
      end
      if (state_ff == S_EA_RD && i_ea_ack)
        opnd_ff <= i_ea_rdata;
    end
  end

  // Register file, condition byte and completion
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      for (int i = 0; i < NUM_DREGS; i++)
        dreg_ff[i] <= DREG_RESET;
      ccr_ff  <= CCR_RESET;
      res_ff  <= 32'h0;
      rd_ff   <= 32'h0;
      done_ff <= 1'b0;
      ill_ff  <= 1'b0;
      trap_ff <= 1'b0;
    end else begin
      rd_ff   <= dreg_ff[i_dreg_rd_idx];
      done_ff <= (state_ff == S_EXEC && nxt_state == S_OP) ||
                 (state_ff == S_EA_WR && i_ea_ack);
      ill_ff  <= (state_ff == S_OP && w_fire && !w_d_ok) ||
                 (state_ff == S_EXT && w_fire && w_ext_bad);
      trap_ff <= state_ff == S_DIVCHK && w_div_zero;
      // Loads are only taken between instructions
      if (state_ff == S_OP && i_dreg_load)
        dreg_ff[i_dreg_load_idx] <= i_dreg_load_data;
      if (state_ff == S_OP && i_ccr_load)
        ccr_ff <= i_ccr_load_data;
      if (state_ff == S_DIVCHK && w_div_zero)
        ccr_ff[CCR_C] <= 1'b0;
      if (state_ff == S_EXEC) begin
        case (kind_ff)
          K_DIV: begin
            ccr_ff[CCR_C] <= 1'b0;
            ccr_ff[CCR_V] <= w_ovf;
            if (!w_ovf) begin
              ccr_ff[CCR_N] <= w_quot[31];
              ccr_ff[CCR_Z] <= w_quot == 32'h0;
              if (dr_ff != dq_ff)
                dreg_ff[dr_ff] <= w_rem;
              dreg_ff[dq_ff] <= w_quot;
            end
          end
          K_CCRXOR: ccr_ff <= ccr_ff ^ imm_ff[4:0];
          default: begin
            ccr_ff[CCR_N] <= w_xneg;
            ccr_ff[CCR_Z] <= w_xres == 32'h0;
            ccr_ff[CCR_V] <= 1'b0;
            ccr_ff[CCR_C] <= 1'b0;
            res_ff        <= w_xres;
            if (w_dst_dn)
              dreg_ff[ea_reg_ff] <= w_merged;
          end
        endcase
      end
    end
  end

  assign o_fetch_ready = state_ff == S_OP || state_ff == S_EXT ||
                         state_ff == S_IMM;
  assign o_ea_req.valid = state_ff == S_EA_RD || state_ff == S_EA_WR;
  assign o_ea_req.write = state_ff == S_EA_WR;
  assign o_ea_req.mode  = mode_ff;
  assign o_ea_req.reg_n = ea_reg_ff;
  assign o_ea_req.size  = size_ff;
  assign o_ea_req.wdata = res_ff;
  assign o_dreg_rd_data  = rd_ff;
  assign o_ccr           = {3'h0, ccr_ff};
  assign o_done          = done_ff;
  assign o_illegal       = ill_ff;
  assign o_div_zero_trap = trap_ff;

  chk_an_source_refused: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    (state_ff == S_OP && w_fire && w_op[15:6] == OP_DIVL_HI &&
     w_mode == EA_MODE_AREG) |=> (o_illegal && state_ff == S_OP))
    else $error("address register divide source accepted");

  chk_zero_trap: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    (state_ff == S_DIVCHK && w_div_zero) |=> (o_div_zero_trap && !o_done))
    else $error("zero divisor did not trap");

  chk_ovf_keeps_dq: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    (state_ff == S_EXEC && w_is_div && w_ovf) |=>
      (ccr_ff[CCR_V] && dreg_ff[dq_ff] == $past(dreg_ff[dq_ff]) &&
       o_done))
    else $error("overflow altered quotient register");

  chk_same_reg_quot: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    (state_ff == S_EXEC && w_is_div && !w_ovf && dr_ff == dq_ff) |=>
      dreg_ff[dq_ff] == $past(w_quot))
    else $error("quotient lost when registers coincide");

  chk_xor_flags: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    (state_ff == S_EXEC && w_is_xor) |=>
      (ccr_ff[CCR_V] == 1'b0 && ccr_ff[CCR_C] == 1'b0 &&
       ccr_ff[CCR_X] == $past(ccr_ff[CCR_X]) &&
       ccr_ff[CCR_Z] == ($past(w_xres) == 32'h0)))
    else $error("xor condition codes wrong");

  chk_ccr_toggle: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    (state_ff == S_EXEC && kind_ff == K_CCRXOR) |=>
      ccr_ff == ($past(ccr_ff) ^ $past(imm_ff[4:0])))
    else $error("condition byte xor wrong");

  chk_byte_upper_kept: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    (state_ff == S_EXEC && w_is_xor && w_dst_dn && size_ff == SZ_BYTE)
    |=> dreg_ff[ea_reg_ff][31:8] == $past(dreg_ff[ea_reg_ff][31:8]))
    else $error("byte xor disturbed upper bits");

  chk_signed_refused: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    (state_ff == S_EXT && w_fire && w_op[EXT_SIGNED_BIT]) |=>
      (o_illegal && state_ff == S_OP))
    else $error("signed divide extension accepted");

  cov_long_divide: cover property (
    @(posedge i_clk) disable iff (i_sys_rst)
    state_ff == S_EXEC && w_is_div && long_ff && !w_ovf);

  cov_mem_xor: cover property (
    @(posedge i_clk) disable iff (i_sys_rst)
    state_ff == S_EA_WR && i_ea_ack);

  cov_ccr_xor: cover property (
    @(posedge i_clk) disable iff (i_sys_rst)
    state_ff == S_EXEC && kind_ff == K_CCRXOR);

endmodule : xldd_decode

// >>> verif/xldd_imem.sv
`timescale 1ns/1ps
module xldd_imem
  import xldd_pkg::*;
(
  input  wire logic         i_clk,
  input  wire logic         i_sys_rst,
  input  wire logic         i_fetch_ready,
  output logic              o_fetch_valid,
  output logic [15:0]       o_fetch_word,
  input  wire xldd_ea_req_t i_ea_req,
  output logic              o_ea_ack,
  output logic [31:0]       o_ea_rdata
);
  logic [15:0]  word_q[$];
  logic [31:0]  mem_cell;
  xldd_ea_req_t last_wr;
  int           ack_wait;
  int           wait_cnt;

  task automatic push(input logic [15:0] w);
    word_q.push_back(w);
  endtask : push

  initial begin
    o_fetch_valid = 1'b0;
    o_fetch_word  = 16'h0000;
    o_ea_ack      = 1'b0;
    o_ea_rdata    = 32'h00000000;
    mem_cell      = 32'h00000000;
    last_wr       = '0;
    ack_wait      = 0;
    wait_cnt      = 0;
  end

  // An idle line shows the inverse of its last value, never stale data
  always @(posedge i_clk) begin
    if (o_fetch_valid && i_fetch_ready && !i_sys_rst) begin
      void'(word_q.pop_front());
    end
    o_fetch_valid <= (word_q.size() != 0);
    o_fetch_word  <= (word_q.size() != 0) ? word_q[0] : ~o_fetch_word;
  end

  // Ack after ack_wait idle cycles; read data only valid with the ack
  always @(posedge i_clk) begin
    o_ea_ack   <= 1'b0;
    o_ea_rdata <= ~o_ea_rdata;
    if (i_ea_req.valid && !o_ea_ack) begin
      wait_cnt <= wait_cnt + 1;
      if (wait_cnt >= ack_wait) begin
        o_ea_ack <= 1'b1;
        wait_cnt <= 0;
        if (i_ea_req.write) begin
          last_wr <= i_ea_req;
        end else begin
          o_ea_rdata <= mem_cell;
        end
      end
    end
  end
endmodule : xldd_imem

// >>> verif/tb_xldd_decode.sv
`timescale 1ns/1ps
module tb_xldd_decode
  import xldd_pkg::*;
;
  localparam logic [15:0] BAD_OP [8] = '{16'hB348, 16'hB37C, 16'hB37A,
    16'hB010, 16'h0A48, 16'h0A7C, 16'h0AC0, 16'h4C48};
  logic         i_clk;
  logic         i_sys_rst;
  logic         f_valid;
  logic         f_ready;
  logic [15:0]  f_word;
  xldd_ea_req_t ea_req;
  logic         ea_ack;
  logic [31:0]  ea_rdata;
  logic         ld;
  logic [2:0]   ld_idx;
  logic [31:0]  ld_data;
  logic         ccr_ld;
  logic [4:0]   ccr_ld_data;
  logic [2:0]   rd_idx;
  logic [31:0]  rd_data;
  logic [7:0]   condition_code_byte;
  logic         done;
  logic         illegal;
  logic         trap;
  int           n_mismatch;
  int           num_checks;
  int           cycles;

  xldd_decode DUT (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_fetch_valid(f_valid), .i_fetch_word(f_word), .o_fetch_ready(f_ready),
    .o_ea_req(ea_req), .i_ea_ack(ea_ack), .i_ea_rdata(ea_rdata),
    .i_dreg_load(ld), .i_dreg_load_idx(ld_idx), .i_dreg_load_data(ld_data),
    .i_ccr_load(ccr_ld), .i_ccr_load_data(ccr_ld_data),
    .i_dreg_rd_idx(rd_idx), .o_dreg_rd_data(rd_data), .o_ccr(condition_code_byte),
    .o_done(done), .o_illegal(illegal), .o_div_zero_trap(trap));
  xldd_imem mem (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_fetch_ready(f_ready), .o_fetch_valid(f_valid), .o_fetch_word(f_word),
    .i_ea_req(ea_req), .o_ea_ack(ea_ack), .o_ea_rdata(ea_rdata));

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  task automatic wrap_up();
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up

  // Long divides plus slow acks stay far below this ceiling
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic put_d(input logic [2:0] idx, input logic [31:0] v);
    @(posedge i_clk);
    ld      <= 1'b1;
    ld_idx  <= idx;
    ld_data <= v;
    @(posedge i_clk);
    ld <= 1'b0;
  endtask : put_d

  task automatic put_ccr(input logic [4:0] v);
    @(posedge i_clk);
    ccr_ld      <= 1'b1;
    ccr_ld_data <= v;
    @(posedge i_clk);
    ccr_ld <= 1'b0;
  endtask : put_ccr

  task automatic get_d(input logic [2:0] idx, output logic [31:0] v);
    @(posedge i_clk);
    rd_idx <= idx;
    @(posedge i_clk);
    @(negedge i_clk);
    v = rd_data;
  endtask : get_d

  task automatic send(input logic [15:0] w);
    @(negedge i_clk);
    mem.push(w);
  endtask : send

  // Expected pulse given as {done, illegal, trap}
  task automatic fin_wait(input logic [2:0] exp);
    logic [2:0] ev;
    ev = 3'b000;
    for (int k = 0; k < 200 && ev == 3'b000; k++) begin
      @(negedge i_clk);
      ev = {done, illegal, trap};
    end
    check("end pulse", {29'h0, exp}, {29'h0, ev});
  endtask : fin_wait

  task automatic t_ccr();
    put_ccr(5'h15);
    send(16'h0A3C);
    send(16'h00FF);
    fin_wait(3'b100);
    check("ccr xor", 32'h0000000A, {24'h0, condition_code_byte});
    send(16'h0A3C);
    send(16'h0001);
    fin_wait(3'b100);
    check("ccr xor c", 32'h0000000B, {24'h0, condition_code_byte});
  endtask : t_ccr

  task automatic imm_case(input logic [1:0] sz, input logic [15:0] hi,
                          input logic [15:0] lo, input logic [31:0] ed,
                          input logic [4:0] ec);
    logic [31:0] d;
    put_d(3'h2, 32'hA5A5A5A5);
    put_ccr(5'h13);
    send({8'h0A, sz, 6'h02});
    if (sz == 2'b10) begin
      send(hi);
    end
    send(lo);
    fin_wait(3'b100);
    get_d(3'h2, d);
    check("imm dreg", ed, d);
    check("imm ccr", {27'h0, ec}, {24'h0, condition_code_byte});
  endtask : imm_case

  task automatic t_regxor();
    logic [31:0] d;
    mem.ack_wait = 3;
    mem.mem_cell = 32'h0000000F;
    put_d(3'h1, 32'h000000F0);
    put_ccr(5'h03);
    send(16'hB310);
    fin_wait(3'b100);
    check("rx wr", 32'h000040FF, {16'h0, mem.last_wr.mode,
      mem.last_wr.reg_n, mem.last_wr.size,
      mem.last_wr.wdata[7:0]});
    check("rx ccr", 32'h00000008, {24'h0, condition_code_byte});
    put_d(3'h2, 32'h80000001);
    put_d(3'h3, 32'h00000001);
    send(16'hB583);
    fin_wait(3'b100);
    get_d(3'h3, d);
    check("rx dreg", 32'h80000000, d);
    mem.ack_wait = 0;
    mem.mem_cell = 32'h00001234;
    send(16'h0A79);
    send(16'h00FF);
    fin_wait(3'b100);
    check("ix abs", 32'h00E512CB, {8'h0, mem.last_wr.mode,
      mem.last_wr.reg_n, mem.last_wr.size,
      mem.last_wr.wdata[15:0]});
  endtask : t_regxor

  task automatic t_illegal();
    for (int k = 0; k < 8; k++) begin
      send(BAD_OP[k]);
      fin_wait(3'b010);
    end
    send(16'h4C41);
    send(16'h2803);
    fin_wait(3'b010);
  endtask : t_illegal

  task automatic div_case(input logic [15:0] op, input logic [15:0] ext,
    input logic [31:0] hi, input logic [31:0] lo, input logic [31:0] dv,
    input logic [2:0] ev, input logic [31:0] eq, input logic [31:0] er,
    input logic [4:0] ec, input logic [4:0] cm);
    logic [31:0] d;
    mem.mem_cell = dv;
    put_d(3'h3, hi);
    put_d(3'h2, lo);
    put_d(3'h1, dv);
    // Start with N Z V C opposite to the outcome so each of N Z V C checked under cm must move
    put_ccr(ec ^ 5'h0F);
    send(op);
    send(ext);
    if (op == 16'h4C7C) begin
      send(dv[31:16]);
      send(dv[15:0]);
    end
    fin_wait(ev);
    get_d(3'h2, d);
    check("div dq", eq, d);
    get_d(3'h3, d);
    check("div dr", er, d);
    check("div ccr", {27'h0, ec & cm}, {24'h0, condition_code_byte & {3'h0, cm}});
  endtask : div_case

  initial begin
    n_mismatch  = 0;
    num_checks  = 0;
    cycles      = 0;
    i_sys_rst   = 1'b1;
    ld          = 1'b0;
    ld_idx      = 3'h0;
    ld_data     = 32'h00000000;
    ccr_ld      = 1'b0;
    ccr_ld_data = 5'h00;
    rd_idx      = 3'h0;
    repeat (5) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    check("reset ccr", 32'h00000000, {24'h0, condition_code_byte});
    t_ccr();
    imm_case(2'b00, 16'h0000, 16'h12FF, 32'hA5A5A55A, 5'h10);
    imm_case(2'b01, 16'h0000, 16'hA5A5, 32'hA5A50000, 5'h14);
    imm_case(2'b10, 16'hA5A5, 16'hA5A4, 32'h00000001, 5'h10);
    t_regxor();
    t_illegal();
    div_case(16'h4C41, 16'h2003, 32'hDEAD0000, 32'h64, 32'h7, 3'b100,
      32'hE, 32'h2, 5'h10, 5'h1F);
    div_case(16'h4C41, 16'h2403, 32'h1, 32'h0, 32'h2, 3'b100,
      32'h80000000, 32'h0, 5'h18, 5'h1F);
    div_case(16'h4C41, 16'h2002, 32'h55, 32'h64, 32'h7, 3'b100,
      32'hE, 32'h55, 5'h10, 5'h1F);
    div_case(16'h4C41, 16'h2403, 32'h5, 32'h0, 32'h5, 3'b100,
      32'h0, 32'h5, 5'h12, 5'h13);
    div_case(16'h4C41, 16'h2403, 32'h4, 32'h0, 32'h5, 3'b100,
      32'hCCCCCCCC, 32'h4, 5'h18, 5'h1F);
    div_case(16'h4C41, 16'h2403, 32'h1, 32'h2, 32'h0, 3'b001,
      32'h2, 32'h1, 5'h10, 5'h11);
    div_case(16'h4C7C, 16'h2003, 32'h0, 32'h64, 32'hA, 3'b100,
      32'hA, 32'h0, 5'h10, 5'h1F);
    div_case(16'h4C50, 16'h2003, 32'h0, 32'h64, 32'h9, 3'b100,
      32'hB, 32'h1, 5'h10, 5'h1F);
    wrap_up();
  end
endmodule : tb_xldd_decode
